// ===== bench/pbc_regs_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the basic control register block.
module pbc_regs_monitor
  import pbc_pkg::*;
#(
  parameter logic [7:0]  SRST_CYCLES = 8'h10,
  parameter logic [31:0] AN_CYCLES   = 32'h0000_0040
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        speed_sel_strap,
  input wire pbc_req_t    req,
  input wire logic        link_up,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        addr_hit,
  input wire pbc_mode_t   mode,
  input wire logic        soft_reset_busy,
  input wire logic        an_complete
);
  logic [4:0] idx_q;
  logic [7:0] busy_q;
  logic       rd;
  logic       dec;
  // Read strobe and the set of decoded indexes.
  assign rd  = req.valid && !req.write;
  assign dec = req.index <= 5'h06 || req.index == 5'h11 ||
               req.index == 5'h12 || req.index == 5'h1B || req.index >= 5'h1D;
  // Index of the last read, so read data can be tied to its register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) idx_q <= 5'h00;
    else if (rd) idx_q <= req.index;
  end
  // Length of the soft reset; a stuck busy flag shows up as a long count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_q <= 8'h00;
    else if (soft_reset_busy) busy_q <= busy_q + 8'h01;
    else busy_q <= 8'h00;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (rd |=> rvalid)
    else $error("read not answered in the next cycle");
  no_spurious_a: assert property (!rd |=> !rvalid)
    else $error("read data strobe without a read");
  hit_decode_a: assert property (req.valid && dec |=> addr_hit)
    else $error("decoded index not flagged");
  miss_zero_a: assert property (rd && !dec |=> !addr_hit && rdata == 16'h0000)
    else $error("unknown index not read as zero");
  ctrl_resv_a: assert property (rvalid && idx_q == 5'h00 |-> (rdata & 16'h047F) == 16'h0000)
    else $error("reserved control bits not zero");
  an_override_a: assert property (mode.an_enable |-> mode.speed_100 && mode.full_duplex)
    else $error("negotiation does not override forced mode");
  srst_len_a: assert property (busy_q <= SRST_CYCLES + 8'h02)
    else $error("soft reset does not clear itself");
  srst_reload_a: assert property ($fell(soft_reset_busy) |-> !mode.loopback && !mode.power_down && !mode.col_test)
    else $error("soft reset left control fields set");
  link_drop_a: assert property (!link_up [*2] |=> !an_complete)
    else $error("negotiation complete without link");
  loop_set_a: assert property (req.valid && req.write && req.index == 5'h00 && !soft_reset_busy && req.wdata[15:14] == 2'b01 |-> ##[1:3] mode.loopback)
    else $error("loopback write not applied");
  cover property (rd && req.index == 5'h00);
  cover property ($rose(soft_reset_busy));
  cover property ($rose(an_complete));
endmodule // pbc_regs_monitor

bind pbc_regs pbc_regs_monitor #(
  .SRST_CYCLES(SRST_CYCLES),
  .AN_CYCLES  (AN_CYCLES)
) u_pbc_regs_monitor (
  .clk(clk), .rst(rst), .speed_sel_strap(speed_sel_strap), .req(req),
  .link_up(link_up), .rdata(rdata), .rvalid(rvalid), .addr_hit(addr_hit),
  .mode(mode), .soft_reset_busy(soft_reset_busy), .an_complete(an_complete)
);

// ===== bench/pbc_regs_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the basic control register block.
module pbc_regs_tb
  import pbc_pkg::*;
;
  localparam logic [31:0] ANC = 32'h0000_0010;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b0;
  logic        link = 1'b0;
  pbc_req_t    req = '0;
  logic [15:0] rdata;
  logic [15:0] rd_v;
  logic [15:0] w;
  logic        rvalid;
  logic        addr_hit;
  logic        busy;
  logic        an_done;
  logic        s;
  pbc_mode_t   mode;
  logic [31:0] seed = 32'h2339;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;

  pbc_regs #(.SRST_CYCLES(8'h10), .AN_CYCLES(ANC)) u_pbc_regs (
    .clk(clk), .rst(rst), .speed_sel_strap(strap), .req(req),
    .link_up(link), .rdata(rdata), .rvalid(rvalid), .addr_hit(addr_hit),
    .mode(mode), .soft_reset_busy(busy), .an_complete(an_done)
  );

  // Clock and a cycle ceiling, so a hang still ends in a verdict.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Effective mode: negotiation forces speed and duplex high.
  function automatic logic [15:0] emode(input logic [15:0] c);
    return {10'h000, c[14], c[13] | c[12], c[8] | c[12], c[12], c[11], c[7]};
  endfunction
  function automatic logic dec(input logic [4:0] i);
    return i <= 5'h06 || i == 5'h11 || i == 5'h12 || i == 5'h1B || i >= 5'h1D;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, held over exactly one taking edge; read data lands after it.
  task automatic acc(input logic wr, input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    #2 req <= '{1'b1, wr, i, d};
    @(posedge clk);
    #2 req.valid <= 1'b0;
    rd_v = rdata;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #2 rst = 1'b0;
    @(posedge clk);
  endtask
  task automatic results();
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    // Both strap levels give their own control defaults.
    for (int k = 0; k < 2; k++) begin
      s = 1'(k);
      strap = s;
      do_reset();
      acc(1'b0, 5'h00, 16'h0000);
      check({15'h0000, rvalid}, 16'h0001);
      check(rd_v, {2'b00, s, s, 12'h000});
      check({10'h000, mode}, emode({2'b00, s, s, 12'h000}));
    end
    acc(1'b0, 5'h01, 16'h0000);
    check(rd_v, 16'h7809);
    // Sweep every index; only the listed ones answer.
    for (int i = 0; i < 32; i++) begin
      acc(1'b0, 5'(i), 16'h0000);
      check({15'h0000, addr_hit}, {15'h0000, dec(5'(i))});
      if (!dec(5'(i))) check(rd_v, 16'h0000);
    end
    acc(1'b1, 5'h04, 16'hFFFF);
    acc(1'b0, 5'h00, 16'h0000);
    check(rd_v, 16'h3000);
    // Random control writes, first one touching reserved bits only.
    for (n = 0; n < 24; n++) begin
      seed = lfsr(seed);
      w = (n == 0) ? 16'h047F : seed[15:0] & 16'h7DFF;
      acc(1'b1, 5'h00, w);
      acc(1'b0, 5'h00, 16'h0000);
      check(rd_v, w & 16'h7980);
      check({10'h000, mode}, emode(w));
    end
    // Soft reset keeps the strap image taken at device reset.
    acc(1'b1, 5'h00, 16'h4980);
    strap = 1'b0;
    acc(1'b1, 5'h00, 16'h8000);
    acc(1'b0, 5'h00, 16'h0000);
    check({15'h0000, rd_v[15]}, 16'h0001);
    acc(1'b1, 5'h00, 16'h4000);
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk);
    #2 check({15'h0000, busy}, 16'h0000);
    acc(1'b0, 5'h00, 16'h0000);
    check(rd_v, 16'h3000);
    check({10'h000, mode}, emode(16'h3000));
    do_reset();
    acc(1'b0, 5'h00, 16'h0000);
    check(rd_v, 16'h0000);
    // Restart negotiation with the link up, then drop the link.
    link = 1'b1;
    acc(1'b1, 5'h00, 16'h1200);
    for (n = 0; n < 40 && an_done !== 1'b1; n++) @(posedge clk);
    #2 check({15'h0000, an_done}, 16'h0001);
    acc(1'b0, 5'h00, 16'h0000);
    check(rd_v, 16'h1000);
    acc(1'b0, 5'h01, 16'h0000);
    check(rd_v, 16'h782D);
    link = 1'b0;
    repeat (4) @(posedge clk);
    #2 check({15'h0000, an_done}, 16'h0000);
    results();
  end
endmodule // pbc_regs_tb

// ===== logic/pbc_an_seq.sv
`timescale 1ns/1ps
`include "pbc_cfg.svh"
// Stand-in negotiation sequencer; counts a fixed time, then reports done.
module pbc_an_seq
  import pbc_pkg::*;
#(
  parameter logic [31:0] AN_CYCLES = `PBC_AN_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  input  wire logic enable,
  input  wire logic start,
  output logic      done
);
  pbc_an_state_t state_q;
  logic [31:0]   cnt_q;

  // Clear or loss of enable always drops back to idle and forgets completion.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PBC_AN_IDLE;
      cnt_q   <= 32'h0000_0000;
    end else if (clr || !enable) begin
      state_q <= PBC_AN_IDLE;
      cnt_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        PBC_AN_IDLE: begin
          // Enabled and not held clear, so a fresh count begins at once.
          state_q <= PBC_AN_BUSY;
          cnt_q   <= 32'h0000_0000;
        end
        PBC_AN_BUSY: begin
          if (start) begin
            cnt_q <= 32'h0000_0000;
          end else if (cnt_q >= AN_CYCLES - 32'h0000_0001) begin
            state_q <= PBC_AN_DONE;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        PBC_AN_DONE: begin
          if (start) begin
            state_q <= PBC_AN_BUSY;
            cnt_q   <= 32'h0000_0000;
          end
        end
        default: state_q <= PBC_AN_IDLE;
      endcase
    end
  end

  always_comb begin
    done = (state_q == PBC_AN_DONE);
  end
endmodule // pbc_an_seq

// ===== logic/pbc_cfg.svh
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH
// Register indexes of the indirectly reached management map.
`define PBC_IDX_BASIC_CONTROL 5'h00
`define PBC_IDX_BASIC_STATUS  5'h01
`define PBC_IDX_ID1           5'h02
`define PBC_IDX_ID2           5'h03
`define PBC_IDX_ADVERTISE     5'h04
`define PBC_IDX_PARTNER       5'h05
`define PBC_IDX_EXPANSION     5'h06
`define PBC_IDX_MODE_CTRL     5'h11
`define PBC_IDX_SPECIAL_MODES 5'h12
`define PBC_IDX_SPECIAL_IND   5'h1B
`define PBC_IDX_INT_SOURCE    5'h1D
`define PBC_IDX_INT_MASK      5'h1E
`define PBC_IDX_SPECIAL_CTRL  5'h1F
// Basic control field positions.
`define PBC_BIT_RESET     15
`define PBC_BIT_LOOPBACK  14
`define PBC_BIT_SPEED     13
`define PBC_BIT_AN_EN     12
`define PBC_BIT_PWR_DOWN  11
`define PBC_BIT_AN_RESTART 9
`define PBC_BIT_DUPLEX     8
`define PBC_BIT_COL_TEST   7
// Basic status field positions and fixed ability bits.
`define PBC_BIT_AN_DONE    5
`define PBC_STATUS_FIXED  16'h7809
// Writable mask of the basic control register.
`define PBC_CTRL_WMASK    16'hFB80
// Soft reset hold in clocks, and negotiation time in clocks.
`define PBC_SRST_CYCLES   8'h10
`define PBC_AN_CYCLES     32'h0000_0040
// Arbitrary identifier values, not tied to any maker.
`define PBC_ID1_VALUE     16'h1234
`define PBC_ID2_VALUE     16'h5678
`endif

// ===== logic/pbc_pkg.sv
package pbc_pkg;
  // One management access as issued by the MAC side.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  index;
    logic [15:0] wdata;
  } pbc_req_t;
  // Effective operating mode seen by the PHY datapath.
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic an_enable;
    logic power_down;
    logic col_test;
  } pbc_mode_t;
  // Negotiation sequencer states.
  typedef enum logic [2:0] {
    PBC_AN_IDLE = 3'b001,
    PBC_AN_BUSY = 3'b010,
    PBC_AN_DONE = 3'b100
  } pbc_an_state_t;
endpackage

// ===== logic/pbc_regs.sv
`timescale 1ns/1ps
`include "pbc_cfg.svh"
// Contract
// - PHY registers are reached only by index through the MAC access pair.
// - Indexes 0-6, 17, 18, 27, 29, 30, 31 are decoded.
// - Kept fields survive only control bit 15 reset, not others.
// - Bit 15 starts soft reset and clears itself.
// - Bit 14 selects loopback; resets to zero.
// - Bit 13 forces 100 Mb/s; ignored while negotiation enabled.
// - Bit 12 enables negotiation, overriding bits 13 and 8.
// - Bit 11 selects power-down; resets to zero.
// - Negotiation completion sets status bit 5.
// - Bit 9 restarts negotiation and clears itself.
// - Bit 8 forces full duplex; ignored under negotiation; resets zero.
// - Speed and negotiation-enable reset values come from the strap.
module pbc_regs
  import pbc_pkg::*;
#(
  parameter logic [7:0]  SRST_CYCLES = `PBC_SRST_CYCLES,
  parameter logic [31:0] AN_CYCLES   = `PBC_AN_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      speed_sel_strap,
  input  wire pbc_req_t  req,
  input  wire logic      link_up,
  output logic [15:0]    rdata,
  output logic           rvalid,
  output logic           addr_hit,
  output pbc_mode_t      mode,
  output logic           soft_reset_busy,
  output logic           an_complete
);
  // Control fields; kept_through_soft_reset holds the strap image.
  logic        loop_q, speed_q, an_en_q, pdn_q, dup_q, col_q;
  logic        srst_q, rstart_q;
  logic [7:0]  srst_cnt_q;
  logic        kept_through_soft_reset_q;
  logic        strap_taken_q;
  logic [15:0] rdata_q, ctrl_rd, stat_rd;
  logic        rvalid_q, hit_q;
  pbc_mode_t   mode_q;
  logic        an_done, an_done_q, srst_d, rstart_d;
  logic        wr_ctrl, rd_any, idx_ok;

  assign wr_ctrl = req.valid && req.write &&
                   (req.index == `PBC_IDX_BASIC_CONTROL) && !srst_q;
  assign rd_any  = req.valid && !req.write;

  always_comb begin
    case (req.index)
      `PBC_IDX_BASIC_CONTROL, `PBC_IDX_BASIC_STATUS, `PBC_IDX_ID1,
      `PBC_IDX_ID2, `PBC_IDX_ADVERTISE, `PBC_IDX_PARTNER,
      `PBC_IDX_EXPANSION, `PBC_IDX_MODE_CTRL, `PBC_IDX_SPECIAL_MODES,
      `PBC_IDX_SPECIAL_IND, `PBC_IDX_INT_SOURCE, `PBC_IDX_INT_MASK,
      `PBC_IDX_SPECIAL_CTRL: idx_ok = 1'b1;
      default: idx_ok = 1'b0;
    endcase
  end

  // Strap is caught by a clock after reset release, never in the reset arm.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kept_through_soft_reset_q <= 1'b0;
    end else if (!strap_taken_q) begin
      kept_through_soft_reset_q <= speed_sel_strap;
    end
  end

  always_comb begin
    srst_d = wr_ctrl && req.wdata[`PBC_BIT_RESET];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_q     <= 1'b0;
      srst_cnt_q <= 8'h00;
    end else if (srst_d) begin
      srst_q     <= 1'b1;
      srst_cnt_q <= SRST_CYCLES - 8'h01;
    end else if (srst_q) begin
      if (srst_cnt_q == 8'h00) begin
        srst_q <= 1'b0;
      end else begin
        srst_cnt_q <= srst_cnt_q - 8'h01;
      end
    end
  end

  // Control bits; soft reset reloads them, strap defaults from kept image.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_q  <= 1'b0;
      speed_q <= 1'b0;
      an_en_q <= 1'b0;
      pdn_q   <= 1'b0;
      dup_q   <= 1'b0;
      col_q   <= 1'b0;
    end else if (!strap_taken_q || srst_q) begin
      loop_q  <= 1'b0;
      speed_q <= strap_taken_q ? kept_through_soft_reset_q
                               : speed_sel_strap;
      an_en_q <= strap_taken_q ? kept_through_soft_reset_q
                               : speed_sel_strap;
      pdn_q   <= 1'b0;
      dup_q   <= 1'b0;
      col_q   <= 1'b0;
    end else if (wr_ctrl) begin
      loop_q  <= req.wdata[`PBC_BIT_LOOPBACK];
      speed_q <= req.wdata[`PBC_BIT_SPEED];
      an_en_q <= req.wdata[`PBC_BIT_AN_EN];
      pdn_q   <= req.wdata[`PBC_BIT_PWR_DOWN];
      dup_q   <= req.wdata[`PBC_BIT_DUPLEX];
      col_q   <= req.wdata[`PBC_BIT_COL_TEST];
    end
  end

  always_comb begin
    rstart_d = wr_ctrl && req.wdata[`PBC_BIT_AN_RESTART];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rstart_q <= 1'b0;
    end else begin
      rstart_q <= rstart_d;
    end
  end

  // Enable and leaving power-down start it from idle; restart recounts.
  // A level start here would pin the counter at zero, so only the pulse.
  pbc_an_seq #(
    .AN_CYCLES (AN_CYCLES)
  ) u_an (
    .clk    (clk),
    .rst    (rst),
    .clr    (srst_q || pdn_q || !link_up),
    .enable (an_en_q),
    .start  (rstart_q),
    .done   (an_done)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      an_done_q <= 1'b0;
    end else begin
      an_done_q <= an_done;
    end
  end

  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`PBC_BIT_RESET]      = srst_q;
    ctrl_rd[`PBC_BIT_LOOPBACK]   = loop_q;
    ctrl_rd[`PBC_BIT_SPEED]      = speed_q;
    ctrl_rd[`PBC_BIT_AN_EN]      = an_en_q;
    ctrl_rd[`PBC_BIT_PWR_DOWN]   = pdn_q;
    ctrl_rd[`PBC_BIT_AN_RESTART] = rstart_q;
    ctrl_rd[`PBC_BIT_DUPLEX]     = dup_q;
    ctrl_rd[`PBC_BIT_COL_TEST]   = col_q;
    ctrl_rd = ctrl_rd & `PBC_CTRL_WMASK;
    stat_rd = `PBC_STATUS_FIXED;
    stat_rd[2] = link_up;
    stat_rd[`PBC_BIT_AN_DONE] = an_done_q;
  end

  // Read data; other decoded indexes read zero since they live elsewhere.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end else begin
      rvalid_q <= rd_any;
      hit_q    <= req.valid && idx_ok;
      if (rd_any) begin
        case (req.index)
          `PBC_IDX_BASIC_CONTROL: rdata_q <= ctrl_rd;
          `PBC_IDX_BASIC_STATUS:  rdata_q <= stat_rd;
          `PBC_IDX_ID1:           rdata_q <= `PBC_ID1_VALUE;
          `PBC_IDX_ID2:           rdata_q <= `PBC_ID2_VALUE;
          default:                rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= '0;
    end else begin
      mode_q.loopback    <= loop_q;
      mode_q.speed_100   <= an_en_q ? 1'b1 : speed_q;
      mode_q.full_duplex <= an_en_q ? 1'b1 : dup_q;
      mode_q.an_enable   <= an_en_q;
      mode_q.power_down  <= pdn_q;
      mode_q.col_test    <= col_q;
    end
  end

  assign rdata           = rdata_q;
  assign rvalid          = rvalid_q;
  assign addr_hit        = hit_q;
  assign mode            = mode_q;
  assign soft_reset_busy = srst_q;
  assign an_complete     = an_done_q;
endmodule // pbc_regs
